/* common/uart_efr_pkg.sv */
package uart_feat_pkg;

   // one register port access
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   // level counter modes, in the order of the two low mode bits
   typedef enum logic [1:0] {CNT_RX, CNT_TX, CNT_RX_ALSO, CNT_ALT} level_mode_t;

   // software flow control selection handed to the flow logic
   typedef struct packed {
      logic [1:0] tx_sel;
      logic [1:0] rx_sel;
      logic       tx_dual;
      logic       rx_dual;
   } swfc_sel_t;

endpackage

/* common/uart_efr_regs.svh */
`ifndef UART_FEAT_REGS_SVH
`define UART_FEAT_REGS_SVH

// ----------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------
`define OFS_SCRATCH     4'h0
`define OFS_DIV_LOW     4'h1
`define OFS_DIV_HIGH    4'h2
`define OFS_PART_ID     4'h3
`define OFS_PART_REV    4'h4
`define OFS_TRIG_PROG   4'h5
`define OFS_DATA_COUNT  4'h6
`define OFS_FEATURE     4'h7
`define OFS_ENH_FEATURE 4'h8
`define OFS_LINE_CTRL   4'h9

// ----------------------------------------------------------------
// reset values and keys
// ----------------------------------------------------------------
`define RST_SCRATCH     8'hFF
`define RST_ZERO        8'h00
`define LINE_CTRL_KEY   8'hBF
`define MSEL_KEEP_MASK  8'h33

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FEAT_IRDA_INV   2
`define FEAT_TXRDY_ALT  3
`define FEAT_SWAP       6
`define FEAT_TRIG_DIR   7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BAUD_OVERSAMPLE 5'd16

`endif

/* hdl/baud_gen.sv */
`timescale 1ns/1ns
`include "uart_efr_regs.svh"
module baud_gen #(
   parameter int DIV_W = 16
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [DIV_W-1:0] divisor,
   output logic                  tick_x16,
   output logic                  baud_tick
);
   logic [DIV_W-1:0] cnt_q, cnt_d;
   logic [3:0]       os_q, os_d;
   logic             x16_d, baud_d;

   // divide by the divisor into the 16x tick, then by 16 into the bit tick
   always_comb begin
      cnt_d  = cnt_q + 1'b1;
      os_d   = os_q;
      x16_d  = 1'b0;
      baud_d = 1'b0;
      if (divisor == '0) begin
         cnt_d = '0; // a zero divisor parks the generator
      end else if (cnt_q >= divisor - 1'b1) begin
         cnt_d  = '0;
         x16_d  = 1'b1;
         os_d   = os_q + 1'b1;
         baud_d = (os_q == 4'(`BAUD_OVERSAMPLE - 5'd1));
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q     <= '0;
         os_q      <= 4'h0;
         tick_x16  <= 1'b0;
         baud_tick <= 1'b0;
      end else begin
         cnt_q     <= cnt_d;
         os_q      <= os_d;
         tick_x16  <= x16_d;
         baud_tick <= baud_d;
      end
   end

   a_x16_period : assert property (@(posedge clk) disable iff (!arst_n)
      (tick_x16 && divisor == 16'd2) ##1 (divisor == 16'd2) |-> !tick_x16 ##1 tick_x16)
      else $error("16x tick period wrong for divisor 2");
endmodule

/* hdl/rts_hyst_lut.sv */
`timescale 1ns/1ns
module rts_hyst_lut (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic [3:0] idx,
   output logic      [5:0] hyst
);
   logic [5:0] hyst_d;

   // character counts indexed by {mode bits 5:4, feature bits 1:0}
   function automatic logic [5:0] hyst_of(input logic [3:0] i);
      logic [5:0] t [16];
      t = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
            6'h28, 6'h2C, 6'h30, 6'h34, 6'h0C, 6'h14, 6'h1C, 6'h24};
      return t[i];
   endfunction

   always_comb begin
      hyst_d = hyst_of(idx);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hyst <= 6'h00;
      end else begin
         hyst <= hyst_d;
      end
   end

   a_hyst_top_row : assert property (@(posedge clk) disable iff (!arst_n)
      (idx == 4'hC) |=> (hyst == 6'd12)) else $error("hysteresis 12 not chosen");
   a_hyst_mid_row : assert property (@(posedge clk) disable iff (!arst_n)
      (idx == 4'h9) |=> (hyst == 6'd44)) else $error("hysteresis 44 not chosen");
endmodule

/* hdl/uart_enhanced_feature_regs.sv */
`timescale 1ns/1ns
`include "uart_efr_regs.svh"
module uart_enhanced_feature_regs #(
   parameter logic [7:0] PART_ID  = 8'h5A, // arbitrary value
   parameter logic [7:0] PART_REV = 8'h03  // arbitrary value
) (
   input  wire logic                    CORE_CLK,
   input  wire logic                    ARST_N,
   input  wire uart_feat_pkg::reg_req_t REG_REQ,
   output logic                  [7:0]  RDATA,
   input  wire logic             [7:0]  RX_FIFO_COUNT,
   input  wire logic             [7:0]  TX_FIFO_COUNT,
   input  wire logic                    IRDA_RX_IN,
   output logic                         IRDA_RX_DATA,
   output logic                         BAUD_X16_TICK,
   output logic                         BAUD_TICK,
   output logic                  [5:0]  RTS_HYST,
   output logic                  [1:0]  TRIG_TABLE,
   output logic                  [7:0]  RX_TRIG_LEVEL,
   output logic                  [7:0]  TX_TRIG_LEVEL,
   output logic                         TXRDY_ALT_MODE,
   output uart_feat_pkg::swfc_sel_t     SWFC,
   output logic                         AUTO_CTS_EN,
   output logic                         AUTO_RTS_EN,
   output logic                         SPECIAL_CHAR_EN,
   output logic                         ENH_WRITE_EN,
   output logic                  [7:0]  LINE_CONTROL
);
   import uart_feat_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]  scratch_q, scratch_d;
   logic [7:0]  msel_q, msel_d;
   logic [7:0]  div_low_q, div_low_d;
   logic [7:0]  div_high_q, div_high_d;
   logic [7:0]  rx_trig_q, rx_trig_d;
   logic [7:0]  tx_trig_q, tx_trig_d;
   logic [7:0]  feat_q, feat_d;
   logic [7:0]  enh_q, enh_d;
   logic [7:0]  line_q, line_d;
   logic        alt_q, alt_d;
   logic [7:0]  rdata_q, rdata_d;
   logic        irda_q, irda_d;
   swfc_sel_t   swfc_q, swfc_d;

   logic        swap_on;
   logic        level_rd;
   level_mode_t mode;

   assign swap_on  = feat_q[`FEAT_SWAP];
   assign mode     = level_mode_t'(msel_q[1:0]);
   assign level_rd = REG_REQ.rd && (REG_REQ.addr == `OFS_SCRATCH) && swap_on;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // which fifo count the level view shows for a mode and phase
   function automatic logic [7:0] level_pick(input level_mode_t m, input logic phase,
                                             input logic [7:0] rx, input logic [7:0] tx);
      logic [7:0] v;
      v = rx;
      case (m)
         CNT_TX:  v = tx;
         CNT_ALT: v = phase ? tx : rx;
         default: v = rx;
      endcase
      return v;
   endfunction

   // flow select fields; dual means both characters of the pair
   function automatic swfc_sel_t swfc_of(input logic [7:0] e);
      swfc_sel_t s;
      s.tx_sel  = e[3:2];
      s.rx_sel  = e[1:0];
      s.tx_dual = (e[3:2] == 2'b11);
      s.rx_dual = (e[1:0] == 2'b11);
      return s;
   endfunction

   // ----------------------------------------------------------------
   // register writes and read mux
   // ----------------------------------------------------------------

   // write decode; a read in the same cycle is decoded after it, so an alternating
   // read's toggle of the alternation flag overrides a swapped write's clear
   always_comb begin
      scratch_d  = scratch_q;
      msel_d     = msel_q;
      div_low_d  = div_low_q;
      div_high_d = div_high_q;
      rx_trig_d  = rx_trig_q;
      tx_trig_d  = tx_trig_q;
      feat_d     = feat_q;
      enh_d      = enh_q;
      line_d     = line_q;
      alt_d      = alt_q;
      rdata_d    = `RST_ZERO;
      if (REG_REQ.wr) begin
         case (REG_REQ.addr)
            `OFS_SCRATCH: begin
               if (swap_on) begin
                  msel_d = REG_REQ.wdata & `MSEL_KEEP_MASK;
                  alt_d  = 1'b0;
               end else begin
                  scratch_d = REG_REQ.wdata;
               end
            end
            `OFS_DIV_LOW:     div_low_d  = REG_REQ.wdata;
            `OFS_DIV_HIGH:    div_high_d = REG_REQ.wdata;
            `OFS_TRIG_PROG: begin
               if (feat_q[`FEAT_TRIG_DIR]) begin
                  tx_trig_d = REG_REQ.wdata;
               end else begin
                  rx_trig_d = REG_REQ.wdata;
               end
            end
            `OFS_FEATURE:     feat_d = REG_REQ.wdata;
            `OFS_ENH_FEATURE: enh_d  = REG_REQ.wdata;
            `OFS_LINE_CTRL:   line_d = REG_REQ.wdata;
            default: ; // read-only and unmapped writes are dropped
         endcase
      end
      if (REG_REQ.rd) begin
         case (REG_REQ.addr)
            `OFS_SCRATCH: begin
               if (swap_on) begin
                  rdata_d = level_pick(mode, alt_q, RX_FIFO_COUNT, TX_FIFO_COUNT);
                  if (mode == CNT_ALT) begin
                     alt_d = ~alt_q;
                  end
               end else begin
                  rdata_d = scratch_q;
               end
            end
            `OFS_DIV_LOW:     rdata_d = div_low_q;
            `OFS_DIV_HIGH:    rdata_d = div_high_q;
            `OFS_PART_ID:     rdata_d = PART_ID;
            `OFS_PART_REV:    rdata_d = PART_REV;
            `OFS_DATA_COUNT: begin
               if (line_q == `LINE_CTRL_KEY) begin
                  rdata_d = feat_q[`FEAT_TRIG_DIR] ? TX_FIFO_COUNT : RX_FIFO_COUNT;
               end
            end
            `OFS_FEATURE:     rdata_d = feat_q;
            `OFS_ENH_FEATURE: rdata_d = enh_q;
            `OFS_LINE_CTRL:   rdata_d = line_q;
            default:          rdata_d = `RST_ZERO; // write-only and unmapped read zero
         endcase
      end
   end

   // register update; divisor bytes have no documented reset, zero is safe
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         scratch_q  <= `RST_SCRATCH;
         msel_q     <= `RST_ZERO;
         div_low_q  <= `RST_ZERO;
         div_high_q <= `RST_ZERO;
         rx_trig_q  <= `RST_ZERO;
         tx_trig_q  <= `RST_ZERO;
         feat_q     <= `RST_ZERO;
         enh_q      <= `RST_ZERO;
         line_q     <= `RST_ZERO;
         alt_q      <= 1'b0;
         rdata_q    <= `RST_ZERO;
      end else begin
         scratch_q  <= scratch_d;
         msel_q     <= msel_d;
         div_low_q  <= div_low_d;
         div_high_q <= div_high_d;
         rx_trig_q  <= rx_trig_d;
         tx_trig_q  <= tx_trig_d;
         feat_q     <= feat_d;
         enh_q      <= enh_d;
         line_q     <= line_d;
         alt_q      <= alt_d;
         rdata_q    <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // infrared polarity and flow select outputs
   // ----------------------------------------------------------------

   // normalise the receive input to idle-low data for the decoder
   always_comb begin
      irda_d = IRDA_RX_IN ^ feat_q[`FEAT_IRDA_INV];
      swfc_d = swfc_of(enh_d);
   end

   // flow select is taken from the next value so it lands with enh_q
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         irda_q <= 1'b0;
         swfc_q <= '0;
      end else begin
         irda_q <= irda_d;
         swfc_q <= swfc_d;
      end
   end

   // ----------------------------------------------------------------
   // submodules
   // ----------------------------------------------------------------

   // hysteresis lags the control writes by one cycle, harmless for a
   // threshold that the flow logic only samples between characters
   rts_hyst_lut u_hyst (
      .clk    (CORE_CLK),
      .arst_n (ARST_N),
      .idx    ({msel_q[5:4], feat_q[1:0]}),
      .hyst   (RTS_HYST)
   );

   baud_gen #(
      .DIV_W (16)
   ) u_baud (
      .clk       (CORE_CLK),
      .arst_n    (ARST_N),
      .divisor   ({div_high_q, div_low_q}),
      .tick_x16  (BAUD_X16_TICK),
      .baud_tick (BAUD_TICK)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign RDATA           = rdata_q;
   assign IRDA_RX_DATA    = irda_q;
   assign TRIG_TABLE      = feat_q[5:4];
   assign RX_TRIG_LEVEL   = rx_trig_q;
   assign TX_TRIG_LEVEL   = tx_trig_q;
   assign TXRDY_ALT_MODE  = feat_q[`FEAT_TXRDY_ALT];
   assign SWFC            = swfc_q;
   assign AUTO_CTS_EN     = enh_q[7];
   assign AUTO_RTS_EN     = enh_q[6];
   assign SPECIAL_CHAR_EN = enh_q[5];
   assign ENH_WRITE_EN    = enh_q[4];
   assign LINE_CONTROL    = line_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_scr_wr;
      REG_REQ.wr && (REG_REQ.addr == `OFS_SCRATCH);
   endsequence

   sequence s_alt_read;
      level_rd && (mode == CNT_ALT);
   endsequence

   a_reset_values : assert property ($rose(ARST_N) |->
      (scratch_q == 8'hFF) && (feat_q[1:0] == 2'b00))
      else $error("reset values wrong");

   a_scratch_plain : assert property ((s_scr_wr and !swap_on) |=>
      (scratch_q == $past(REG_REQ.wdata)))
      else $error("scratch write lost");

   a_scratch_read : assert property ((REG_REQ.rd && REG_REQ.addr == `OFS_SCRATCH
      && !swap_on) |=> (RDATA == $past(scratch_q)))
      else $error("scratch read wrong");

   a_swap_to_mode : assert property ((s_scr_wr and swap_on) |=>
      $stable(scratch_q) && (msel_q == ($past(REG_REQ.wdata) & 8'h33)) && !alt_q)
      else $error("swapped write not sent to mode select");

   a_mode_reserved : assert property ((msel_q[7:6] == 2'b00) && (msel_q[3:2] == 2'b00))
      else $error("reserved mode bits held a one");

   a_level_tx_mode : assert property ((level_rd && mode == CNT_TX) |=>
      (RDATA == $past(TX_FIFO_COUNT)))
      else $error("transmit count mode read wrong");

   a_level_rx_mode : assert property ((level_rd && mode == CNT_RX_ALSO) |=>
      (RDATA == $past(RX_FIFO_COUNT)))
      else $error("receive count mode read wrong");

   a_alt_flip : assert property (s_alt_read |=>
      (alt_q != $past(alt_q)) &&
      (RDATA == ($past(alt_q) ? $past(TX_FIFO_COUNT) : $past(RX_FIFO_COUNT))))
      else $error("alternating count out of step");

   a_count_gate : assert property ((REG_REQ.rd && REG_REQ.addr == `OFS_DATA_COUNT) |=>
      (RDATA == (($past(line_q) != 8'hBF) ? 8'h00 :
                 ($past(feat_q[7]) ? $past(TX_FIFO_COUNT) : $past(RX_FIFO_COUNT)))))
      else $error("data count gating wrong");

   a_trig_steer : assert property ((REG_REQ.wr && REG_REQ.addr == `OFS_TRIG_PROG
      && !feat_q[7]) |=> (rx_trig_q == $past(REG_REQ.wdata)) && $stable(tx_trig_q))
      else $error("receive trigger write misdirected");

   a_irda_polar : assert property (##1 (IRDA_RX_DATA == ($past(IRDA_RX_IN) ^ $past(feat_q[2]))))
      else $error("infrared polarity wrong");

   a_flow_dual : assert property ((SWFC.tx_dual == (enh_q[3:2] == 2'b11)) &&
      (SWFC.rx_dual == (enh_q[1:0] == 2'b11)))
      else $error("dual flow select wrong");

   a_id_fixed : assert property ((REG_REQ.rd && REG_REQ.addr == `OFS_PART_REV) |=>
      (RDATA == PART_REV))
      else $error("revision read wrong");

   a_id_read : assert property ((REG_REQ.rd && REG_REQ.addr == `OFS_PART_ID) |=>
      (RDATA == PART_ID))
      else $error("part id read wrong");

   // plain receive mode, the one that the alternate mode starts from
   a_level_rx_plain : assert property ((level_rd && mode == CNT_RX) |=>
      (RDATA == $past(RX_FIFO_COUNT)))
      else $error("plain receive count read wrong");

   // a write to the trigger port must land in exactly one of the two levels
   sequence s_trig_wr;
      REG_REQ.wr && (REG_REQ.addr == `OFS_TRIG_PROG);
   endsequence

   a_trig_tx_steer : assert property ((s_trig_wr and feat_q[`FEAT_TRIG_DIR]) |=>
      (tx_trig_q == $past(REG_REQ.wdata)) && $stable(rx_trig_q))
      else $error("transmit trigger write misdirected");
endmodule

/* verif/host_bus_model.sv */
`timescale 1ns/1ns
`include "uart_efr_regs.svh"
// host side of the register port; strobes are one cycle, bus idles between accesses
module host_bus_model (
   input  wire logic                   clk,
   output uart_feat_pkg::reg_req_t     req,
   input  wire logic             [7:0] rdata
);
   import uart_feat_pkg::*;

   initial req = '0;

   // write strobe taken at the next edge, bus released at that same edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
   endtask

   // read data stands only in the cycle after the taking edge, so sample it there
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      #1 d = rdata;
   endtask

   // flow select is cleared first so the flow logic never sees a mixed setting
   task automatic flow_prog(input logic [7:0] v);
      wr(`OFS_ENH_FEATURE, 8'h00);
      wr(`OFS_ENH_FEATURE, v);
   endtask

   // divisor bytes are zeroed before any identity read
   task automatic id_rd(input logic [3:0] a, output logic [7:0] d);
      wr(`OFS_DIV_LOW, 8'h00);
      wr(`OFS_DIV_HIGH, 8'h00);
      rd(a, d);
   endtask
endmodule

/* verif/test_uart_enhanced_feature_regs.sv */
`timescale 1ns/1ns
`include "uart_efr_regs.svh"
module test_uart_enhanced_feature_regs;
   import uart_feat_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam logic [7:0] ID_VAL  = 8'h5A; // arbitrary value
   localparam logic [7:0] REV_VAL = 8'h03; // arbitrary value
   logic        core_clk;
   logic        arst_n;
   reg_req_t    req;
   logic [7:0]  rdata;
   logic [7:0]  rx_cnt;
   logic [7:0]  tx_cnt;
   logic        irda_in;
   logic        irda_out;
   logic        x16_tick;
   logic        bit_tick;
   logic [5:0]  rts_hyst;
   logic [1:0]  trig_table;
   logic [7:0]  rx_trig;
   logic [7:0]  tx_trig;
   logic [7:0]  line_ctl;
   logic        txrdy_alt;
   logic        cts_en;
   logic        rts_en;
   logic        spec_en;
   logic        enh_en;
   swfc_sel_t   swfc;
   int          err_count;
   int          cmp_count;
   logic [7:0]  v;
   int          n;
   logic [5:0]  hyst_tbl [16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};

   uart_enhanced_feature_regs #(.PART_ID(ID_VAL), .PART_REV(REV_VAL)) u_uart_enhanced_feature_regs (
      .CORE_CLK(core_clk), .ARST_N(arst_n), .REG_REQ(req), .RDATA(rdata),
      .RX_FIFO_COUNT(rx_cnt), .TX_FIFO_COUNT(tx_cnt), .IRDA_RX_IN(irda_in),
      .IRDA_RX_DATA(irda_out), .BAUD_X16_TICK(x16_tick), .BAUD_TICK(bit_tick),
      .RTS_HYST(rts_hyst), .TRIG_TABLE(trig_table), .RX_TRIG_LEVEL(rx_trig),
      .TX_TRIG_LEVEL(tx_trig), .TXRDY_ALT_MODE(txrdy_alt), .SWFC(swfc),
      .AUTO_CTS_EN(cts_en), .AUTO_RTS_EN(rts_en), .SPECIAL_CHAR_EN(spec_en),
      .ENH_WRITE_EN(enh_en), .LINE_CONTROL(line_ctl)
   );

   host_bus_model u_host_bus_model (.clk(core_clk), .req(req), .rdata(rdata));

   // 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      u_host_bus_model.rd(a, v);
      chk(v, e);
   endtask

   // bounded wait for the next tick; n counts the edges waited
   task automatic wait_tick(input logic bt, output int k);
      k = 0;
      do begin
         @(posedge core_clk);
         #1 k++;
      end while (((bt ? bit_tick : x16_tick) !== 1'b1) && k < 9000);
      if (k >= 9000) begin
         err_count++;
         $display("wrong value at %0t: no baud tick within bound", $time);
         close_out();
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rdc(`OFS_SCRATCH, 8'hFF);
      rdc(`OFS_FEATURE, 8'h00);
      chk(rts_hyst, 0);
   endtask

   // counts are chosen distinct so a wrong source shows
   task automatic t_swap();
      @(posedge core_clk);
      rx_cnt <= 8'h11;
      tx_cnt <= 8'h2E;
      u_host_bus_model.wr(`OFS_FEATURE, 8'h40);
      for (int m = 0; m < 3; m++) begin
         u_host_bus_model.wr(`OFS_SCRATCH, {6'h33, m[1:0]});
         rdc(`OFS_SCRATCH, (m == 1) ? 8'h2E : 8'h11);
      end
      u_host_bus_model.wr(`OFS_SCRATCH, 8'hCF);
      rdc(`OFS_SCRATCH, 8'h11);
      rdc(`OFS_SCRATCH, 8'h2E);
      rdc(`OFS_SCRATCH, 8'h11);
      u_host_bus_model.wr(`OFS_SCRATCH, 8'hCF);
      rdc(`OFS_SCRATCH, 8'h11);
      u_host_bus_model.wr(`OFS_FEATURE, 8'h00);
      rdc(`OFS_SCRATCH, 8'hFF);
   endtask

   task automatic t_scratch();
      u_host_bus_model.wr(`OFS_SCRATCH, 8'hA5);
      rdc(`OFS_SCRATCH, 8'hA5);
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      rdc(`OFS_SCRATCH, 8'hFF);
   endtask

   // reserved mode bits are set in every write and must change nothing
   task automatic t_hyst();
      for (int i = 0; i < 16; i++) begin
         u_host_bus_model.wr(`OFS_FEATURE, {6'h10, i[1:0]});
         u_host_bus_model.wr(`OFS_SCRATCH, {2'b11, i[3:2], 4'hC});
         tick(1);
         chk(rts_hyst, hyst_tbl[i]);
      end
   endtask

   task automatic t_trig();
      for (int t = 0; t < 4; t++) begin
         u_host_bus_model.wr(`OFS_FEATURE, {2'b00, t[1:0], 4'h8});
         #1;
         chk(trig_table, t[1:0]);
         chk(txrdy_alt, 1'b1);
      end
      u_host_bus_model.wr(`OFS_FEATURE, 8'h00);
      #1;
      chk(txrdy_alt, 1'b0);
      u_host_bus_model.wr(`OFS_TRIG_PROG, 8'h21);
      u_host_bus_model.wr(`OFS_FEATURE, 8'h80);
      u_host_bus_model.wr(`OFS_TRIG_PROG, 8'h32);
      #1;
      chk({rx_trig, tx_trig}, 16'h2132);
      rdc(`OFS_TRIG_PROG, 8'h00);
   endtask

   task automatic t_count();
      u_host_bus_model.wr(`OFS_FEATURE, 8'h00);
      rdc(`OFS_DATA_COUNT, 8'h00);
      u_host_bus_model.wr(`OFS_LINE_CTRL, 8'hBF);
      #1;
      chk(line_ctl, 8'hBF);
      rdc(`OFS_DATA_COUNT, 8'h11);
      u_host_bus_model.wr(`OFS_FEATURE, 8'h80);
      rdc(`OFS_DATA_COUNT, 8'h2E);
      u_host_bus_model.wr(`OFS_LINE_CTRL, 8'h00);
   endtask

   task automatic t_irda();
      @(posedge core_clk);
      irda_in <= 1'b1;
      u_host_bus_model.wr(`OFS_FEATURE, 8'h00);
      tick(1);
      chk(irda_out, 1'b1);
      u_host_bus_model.wr(`OFS_FEATURE, 8'h04);
      tick(1);
      chk(irda_out, 1'b0);
   endtask

   // the first wait aligns to a tick, the second measures one period
   task automatic t_baud();
      // divisor 2 first, so the generator's own period check gets exercised
      u_host_bus_model.wr(`OFS_DIV_LOW, 8'h02);
      wait_tick(1'b0, n);
      wait_tick(1'b0, n);
      chk(n, 2);
      wait_tick(1'b1, n);
      wait_tick(1'b1, n);
      chk(n, 32);
      u_host_bus_model.wr(`OFS_DIV_HIGH, 8'h01);
      u_host_bus_model.wr(`OFS_DIV_LOW, 8'h02);
      wait_tick(1'b0, n);
      wait_tick(1'b0, n);
      chk(n, 258);
      rdc(`OFS_DIV_HIGH, 8'h01);
   endtask

   task automatic t_id();
      u_host_bus_model.id_rd(`OFS_PART_ID, v);
      chk(v, ID_VAL);
      u_host_bus_model.wr(`OFS_PART_ID, 8'h00);
      u_host_bus_model.id_rd(`OFS_PART_ID, v);
      chk(v, ID_VAL);
      u_host_bus_model.id_rd(`OFS_PART_REV, v);
      chk(v, REV_VAL);
      rdc(4'hA, 8'h00);
   endtask

   task automatic t_efr();
      u_host_bus_model.flow_prog(8'hFF);
      #1;
      chk({swfc, cts_en, rts_en, spec_en, enh_en}, 16'h03FF);
      u_host_bus_model.flow_prog(8'h09);
      #1;
      chk({swfc, cts_en, rts_en, spec_en, enh_en}, 16'h0240);
      rdc(`OFS_ENH_FEATURE, 8'h09);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      err_count = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      rx_cnt = 8'h00;
      tx_cnt = 8'h00;
      irda_in = 1'b0;
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      t_reset();
      t_swap();
      t_scratch();
      t_hyst();
      t_trig();
      t_count();
      t_irda();
      t_baud();
      t_id();
      t_efr();
      close_out();
   end
endmodule
